// File: rtl/abx_consts.svh
// constants for the alu and branch execution unit
// assumes an 8-bit core with a 16-bit word-addressed program counter
`ifndef ABX_CONSTS_SVH
`define ABX_CONSTS_SVH

// flag register bit positions
`define ABX_FLAG_C        3'h0
`define ABX_FLAG_Z        3'h1
`define ABX_FLAG_N        3'h2
`define ABX_FLAG_V        3'h3
`define ABX_FLAG_S        3'h4
`define ABX_FLAG_H        3'h5
`define ABX_FLAG_RESET    8'h00

// operand constants
`define ABX_BYTE_ONES     8'hff
`define ABX_BYTE_ZERO     8'h00
`define ABX_WORD_ZERO     16'h0000

// cycle counts
`define ABX_CYC_NONE      2'h0
`define ABX_CYC_ONE       2'h1
`define ABX_CYC_TWO       2'h2
`define ABX_CYC_THREE     2'h3

// program counter advances, in words
`define ABX_PC_STEP       16'h0001
`define ABX_PC_SKIP_ONE   16'h0002
`define ABX_PC_SKIP_TWO   16'h0003

`endif

// File: rtl/abx_exec.sv
// alu, compare, skip and branch execution unit of an 8-bit core
// assumes a decoder that presents operands already read from the register file
//
// Contract
// - add and add-with-carry, one cycle, zcnvh
// - word pair plus constant, two cycles, zcnvs
// - subtract register or constant, one cycle, zcnvh
// - subtract with borrow, one cycle, zcnvh
// - word pair minus constant, two cycles, zcnvs
// - and, or, xor: one cycle, z n v
// - mask set ors, mask clear ands complement
// - zero sign probe ands register with itself
// - jumps: z pointer or relative, two cycles
// - calls: z pointer or relative, three cycles
// - skip on equal: pc plus two or three
// - compares set flags, store nothing, one cycle
// - register bit test skips following instruction
// - i/o bit test skips following instruction
// - flag branches: one cycle untaken, two taken
`timescale 1ns/1ps
`include "abx_consts.svh"

module abx_exec
  import abx_pkg::*;
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     rst_b,
  // instruction request
  input  wire logic     req_valid,
  output logic          req_ready,
  input  wire abx_req_t req,
  // completion
  output logic          done,
  output abx_res_t      res,
  output logic [7:0]    flags
);

  // ************************************************************
  // state
  // ************************************************************
  abx_state_t  state;       // sequencer state
  abx_state_t  next_state;
  logic [1:0]  cnt;         // wait cycles left after this one
  logic [1:0]  next_cnt;
  abx_res_t    next_res;    // result latched at acceptance
  logic [7:0]  next_flags;  // flags latched at acceptance

  // ************************************************************
  // datapath scratch
  // ************************************************************
  logic [7:0]  opb;         // second operand
  logic        cin;         // carry or borrow in
  logic [8:0]  sum9;        // byte sum with carry out
  logic [8:0]  dif9;        // byte difference with borrow out
  logic [7:0]  r8;          // byte result for flags
  logic [15:0] w16;         // word result
  logic [15:0] rel_pc;      // pc plus offset plus one
  logic [15:0] seq_pc;      // pc plus one
  logic [15:0] skip_pc;     // pc past the next instruction
  logic [1:0]  skip_cyc;    // cycles when skipping
  logic [1:0]  cyc;         // cycles of this instruction
  logic        skip;        // skip condition met
  logic        take;        // branch condition met
  logic        accept;      // request taken this cycle

  assign accept    = req_valid & req_ready;
  assign req_ready = (state != abx_st_wait);
  assign done      = (state == abx_st_done);

  // ************************************************************
  // shared operand and address arithmetic
  // ************************************************************
  always_comb begin
    // immediate forms take the constant as second operand
    unique case (req.cmd)
      abx_minus_immediate, abx_minus_imm_borrow, abx_conjunction_imm,
      abx_disjunction_imm, abx_set_mask_bits, abx_compare_immediate: begin
        opb = req.imm;
      end
      abx_clear_mask_bits: begin
        opb = `ABX_BYTE_ONES - req.imm;
      end
      abx_zero_sign_probe: begin
        opb = req.rd_val;
      end
      default: begin
        opb = req.rr_val;
      end
    endcase
    // carry enters only the carry and borrow forms
    cin = ((req.cmd == abx_add_carry) || (req.cmd == abx_minus_regs_borrow) ||
           (req.cmd == abx_minus_imm_borrow) || (req.cmd == abx_compare_regs_with_borrow))
          ? flags[`ABX_FLAG_C] : 1'b0;
    sum9    = {1'b0, req.rd_val} + {1'b0, opb} + {8'h00, cin};
    dif9    = {1'b0, req.rd_val} - {1'b0, opb} - {8'h00, cin};
    seq_pc  = req.pc + `ABX_PC_STEP;
    rel_pc  = req.pc + {{4{req.offset[11]}}, req.offset} + `ABX_PC_STEP;
    // a two word follower costs one more word and one more cycle
    skip_pc  = req.next_two_word ? req.pc + `ABX_PC_SKIP_TWO
                                 : req.pc + `ABX_PC_SKIP_ONE;
    skip_cyc = req.next_two_word ? `ABX_CYC_THREE : `ABX_CYC_TWO;
    // skip and branch conditions
    unique case (req.cmd)
      abx_skip_on_equal:     skip = (req.rd_val == req.rr_val);
      abx_skip_reg_bit_low:  skip = ~req.rr_val[req.bit_sel];
      abx_skip_reg_bit_high: skip = req.rr_val[req.bit_sel];
      abx_skip_io_bit_low:   skip = ~req.io_val[req.bit_sel];
      abx_skip_io_bit_high:  skip = req.io_val[req.bit_sel];
      default:               skip = 1'b0;
    endcase
    unique case (req.cmd)
      abx_branch_flag_high:    take = flags[req.flag_sel];
      abx_branch_flag_low:     take = ~flags[req.flag_sel];
      abx_branch_on_zero_flag: take = flags[`ABX_FLAG_Z];
      default:                 take = 1'b0;
    endcase
  end

  // ************************************************************
  // per-command result, flags and cycle count
  // ************************************************************
  always_comb begin
    next_res           = res;
    next_flags         = flags;
    r8                 = `ABX_BYTE_ZERO;
    w16                = `ABX_WORD_ZERO;
    cyc                = `ABX_CYC_ONE;
    if (accept) begin
      // default: no write, fall through to next word
      next_res.wb_en     = 1'b0;
      next_res.wb_pair   = 1'b0;
      next_res.wb_idx    = req.dst;
      next_res.wb_data   = `ABX_WORD_ZERO;
      next_res.pc_next   = seq_pc;
      next_res.push_en   = 1'b0;
      next_res.push_addr = seq_pc;
      unique case (req.cmd)
        // additions
        abx_add, abx_add_carry: begin
          r8 = sum9[7:0];
          next_res.wb_en = 1'b1;
          next_res.wb_data = {8'h00, r8};
          next_flags[`ABX_FLAG_C] = sum9[8];
          next_flags[`ABX_FLAG_H] = (req.rd_val[3] & opb[3]) | (opb[3] & ~r8[3]) |
                                    (~r8[3] & req.rd_val[3]);
          next_flags[`ABX_FLAG_V] = (req.rd_val[7] & opb[7] & ~r8[7]) |
                                    (~req.rd_val[7] & ~opb[7] & r8[7]);
          next_flags[`ABX_FLAG_N] = r8[7];
          next_flags[`ABX_FLAG_Z] = (r8 == `ABX_BYTE_ZERO);
        end
        // subtractions and compares share the borrow arithmetic
        abx_minus_regs, abx_minus_immediate, abx_minus_regs_borrow, abx_minus_imm_borrow,
        abx_compare_regs, abx_compare_regs_with_borrow, abx_compare_immediate: begin
          r8 = dif9[7:0];
          // compares drop the difference
          next_res.wb_en = (req.cmd != abx_compare_regs) &&
                           (req.cmd != abx_compare_regs_with_borrow) &&
                           (req.cmd != abx_compare_immediate);
          next_res.wb_data = {8'h00, r8};
          next_flags[`ABX_FLAG_C] = (~req.rd_val[7] & opb[7]) | (opb[7] & r8[7]) |
                                    (r8[7] & ~req.rd_val[7]);
          next_flags[`ABX_FLAG_H] = (~req.rd_val[3] & opb[3]) | (opb[3] & r8[3]) |
                                    (r8[3] & ~req.rd_val[3]);
          next_flags[`ABX_FLAG_V] = (req.rd_val[7] & ~opb[7] & ~r8[7]) |
                                    (~req.rd_val[7] & opb[7] & r8[7]);
          next_flags[`ABX_FLAG_N] = r8[7];
          // borrow forms keep zero only if it was already set
          if (cin || (req.cmd == abx_minus_regs_borrow) || (req.cmd == abx_minus_imm_borrow) ||
              (req.cmd == abx_compare_regs_with_borrow)) begin
            next_flags[`ABX_FLAG_Z] = (r8 == `ABX_BYTE_ZERO) & flags[`ABX_FLAG_Z];
          end else begin
            next_flags[`ABX_FLAG_Z] = (r8 == `ABX_BYTE_ZERO);
          end
        end
        // word pair arithmetic, two cycles
        abx_word_pair_plus_imm, abx_word_pair_minus_imm: begin
          cyc = `ABX_CYC_TWO;
          if (req.cmd == abx_word_pair_plus_imm) begin
            w16 = req.pair_val + {8'h00, req.imm};
            next_flags[`ABX_FLAG_C] = ~w16[15] & req.pair_val[15];
            next_flags[`ABX_FLAG_V] = ~req.pair_val[15] & w16[15];
          end else begin
            w16 = req.pair_val - {8'h00, req.imm};
            next_flags[`ABX_FLAG_C] = w16[15] & ~req.pair_val[15];
            next_flags[`ABX_FLAG_V] = req.pair_val[15] & ~w16[15];
          end
          next_res.wb_en   = 1'b1;
          next_res.wb_pair = 1'b1;
          next_res.wb_data = w16;
          next_flags[`ABX_FLAG_N] = w16[15];
          next_flags[`ABX_FLAG_Z] = (w16 == `ABX_WORD_ZERO);
          next_flags[`ABX_FLAG_S] = w16[15] ^ next_flags[`ABX_FLAG_V];
        end
        // logic family: carry untouched, overflow cleared
        abx_conjunction, abx_conjunction_imm, abx_disjunction, abx_disjunction_imm,
        abx_exclusive_disjunction, abx_set_mask_bits, abx_clear_mask_bits,
        abx_zero_sign_probe: begin
          if ((req.cmd == abx_disjunction) || (req.cmd == abx_disjunction_imm) ||
              (req.cmd == abx_set_mask_bits)) begin
            r8 = req.rd_val | opb;
          end else if (req.cmd == abx_exclusive_disjunction) begin
            r8 = req.rd_val ^ opb;
          end else begin
            r8 = req.rd_val & opb;
          end
          next_res.wb_en = 1'b1;
          next_res.wb_data = {8'h00, r8};
          next_flags[`ABX_FLAG_V] = 1'b0;
          next_flags[`ABX_FLAG_N] = r8[7];
          next_flags[`ABX_FLAG_Z] = (r8 == `ABX_BYTE_ZERO);
        end
        // jumps and calls, flags untouched
        abx_pc_relative_jump: begin
          cyc = `ABX_CYC_TWO;
          next_res.pc_next = rel_pc;
        end
        abx_jump_via_pointer: begin
          cyc = `ABX_CYC_TWO;
          next_res.pc_next = req.z_ptr;
        end
        abx_pc_relative_call, abx_call_via_pointer: begin
          cyc = `ABX_CYC_THREE;
          next_res.pc_next = (req.cmd == abx_call_via_pointer) ? req.z_ptr : rel_pc;
          next_res.push_en = 1'b1;
        end
        // skips, flags untouched
        abx_skip_on_equal, abx_skip_reg_bit_low, abx_skip_reg_bit_high,
        abx_skip_io_bit_low, abx_skip_io_bit_high: begin
          if (skip) begin
            cyc = skip_cyc;
            next_res.pc_next = skip_pc;
          end
        end
        // conditional branches, flags untouched
        abx_branch_flag_high, abx_branch_flag_low, abx_branch_on_zero_flag: begin
          if (take) begin
            cyc = `ABX_CYC_TWO;
            next_res.pc_next = rel_pc;
          end
        end
        default: begin
          cyc = `ABX_CYC_ONE;
        end
      endcase
    end
  end

  // ************************************************************
  // sequencer next state
  // ************************************************************
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      abx_st_idle, abx_st_done: begin
        if (accept) begin
          // single cycle work completes straight away
          next_state = (cyc == `ABX_CYC_ONE) ? abx_st_done : abx_st_wait;
          next_cnt   = cyc - `ABX_CYC_TWO;
        end else begin
          next_state = abx_st_idle;
        end
      end
      abx_st_wait: begin
        // hold for the remaining cycles of multi-cycle work
        if (cnt == `ABX_CYC_NONE) begin
          next_state = abx_st_done;
        end else begin
          next_cnt = cnt - `ABX_CYC_ONE;
        end
      end
      default: begin
        next_state = abx_st_idle;
      end
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= abx_st_idle;
      cnt   <= `ABX_CYC_NONE;
      res   <= '0;
      flags <= `ABX_FLAG_RESET;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      res   <= next_res;
      flags <= next_flags;
    end
  end

endmodule : abx_exec

// File: rtl/abx_pkg.sv
// types for the alu and branch execution unit
// assumes abx_consts.svh is included by the design file
package abx_pkg;

  // commands handed over by the decoder
  typedef enum logic [4:0] {
    abx_nop, abx_add, abx_add_carry, abx_word_pair_plus_imm,
    abx_minus_regs, abx_minus_immediate, abx_minus_regs_borrow, abx_minus_imm_borrow,
    abx_word_pair_minus_imm, abx_conjunction, abx_conjunction_imm, abx_disjunction,
    abx_disjunction_imm, abx_exclusive_disjunction, abx_set_mask_bits, abx_clear_mask_bits,
    abx_zero_sign_probe, abx_pc_relative_jump, abx_jump_via_pointer, abx_pc_relative_call,
    abx_call_via_pointer, abx_skip_on_equal, abx_compare_regs, abx_compare_regs_with_borrow,
    abx_compare_immediate, abx_skip_reg_bit_low, abx_skip_reg_bit_high, abx_skip_io_bit_low,
    abx_skip_io_bit_high, abx_branch_flag_high, abx_branch_flag_low, abx_branch_on_zero_flag
  } abx_cmd_t;

  // one decoded instruction with its fetched operands
  typedef struct packed {
    abx_cmd_t    cmd;           // operation
    logic [4:0]  dst;           // destination register (low register of a pair)
    logic [15:0] pc;            // address of this instruction
    logic [7:0]  rd_val;        // destination register contents
    logic [7:0]  rr_val;        // source register contents
    logic [7:0]  imm;           // immediate constant
    logic [15:0] pair_val;      // high:low register pair contents
    logic [15:0] z_ptr;         // z pointer pair contents
    logic [11:0] offset;        // signed relative offset
    logic [2:0]  flag_sel;      // flag register bit for branches
    logic [2:0]  bit_sel;       // bit for register or i/o bit tests
    logic [7:0]  io_val;        // addressed i/o register contents
    logic        next_two_word; // following instruction is two words long
  } abx_req_t;

  // result handed back at completion
  typedef struct packed {
    logic        wb_en;     // write result to register file
    logic        wb_pair;   // write both bytes of a pair
    logic [4:0]  wb_idx;    // destination register
    logic [15:0] wb_data;   // result, low byte alone unless wb_pair
    logic [15:0] pc_next;   // next program counter
    logic        push_en;   // push return address onto the stack
    logic [15:0] push_addr; // return address
  } abx_res_t;

  // sequencer states, gray coded along idle, wait, done
  typedef enum logic [1:0] {
    abx_st_idle = 2'b00,
    abx_st_wait = 2'b01,
    abx_st_done = 2'b11
  } abx_state_t;

endpackage : abx_pkg

// File: verification/abx_exec_properties.sv
// assertion checker for the alu and branch execution unit
// assumes it is bound to abx_exec and sees only that module's ports
`timescale 1ns/1ps
module abx_exec_properties
  import abx_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // request and completion
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire abx_req_t   req,
  input wire logic       done,
  input wire abx_res_t   res,
  input wire logic [7:0] flags
);
  // ****************************************
  // properties on the request/completion pair
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // a request taken at this edge, qualified by a condition
  sequence s_take(b);
    req_valid && req_ready && b;
  endsequence
  // two quiet cycles before completion
  sequence s_wait_two;
    !done ##1 !done;
  endsequence

  property p_add;
    s_take(req.cmd == abx_add) |=>
      done && res.wb_data[7:0] == 8'($past(req.rd_val) + $past(req.rr_val));
  endproperty
  property p_word;
    s_take(req.cmd inside {abx_word_pair_plus_imm, abx_word_pair_minus_imm}) |=>
      !req_ready ##1 done;
  endproperty
  property p_call;
    s_take(req.cmd inside {abx_pc_relative_call, abx_call_via_pointer}) |=>
      s_wait_two ##1 (done && res.push_en && res.push_addr == $past(req.pc, 3) + 16'h0001);
  endproperty
  property p_jptr;
    s_take(req.cmd == abx_jump_via_pointer) |=>
      !done ##1 (done && res.pc_next == $past(req.z_ptr, 2));
  endproperty
  property p_keep_c;
    s_take(req.cmd inside {abx_conjunction, abx_disjunction, abx_exclusive_disjunction}) |=>
      flags[0] == $past(flags[0]);
  endproperty
  property p_br_untaken;
    s_take(req.cmd == abx_branch_flag_high && !flags[req.flag_sel]) |=>
      done && res.pc_next == $past(req.pc) + 16'h0001;
  endproperty
  property p_cmp;
    s_take(req.cmd inside {abx_compare_regs, abx_compare_immediate}) |=> done && !res.wb_en;
  endproperty
  property p_skip;
    s_take(req.cmd == abx_skip_on_equal && req.rd_val == req.rr_val && req.next_two_word) |=>
      s_wait_two ##1 (done && res.pc_next == $past(req.pc, 3) + 16'h0003);
  endproperty

  a_add: assert property (p_add) else $error("add result wrong");
  a_word: assert property (p_word) else $error("word op timing wrong");
  a_call: assert property (p_call) else $error("call timing or push wrong");
  a_jptr: assert property (p_jptr) else $error("pointer jump wrong");
  a_keep_c: assert property (p_keep_c) else $error("logic op changed carry");
  a_br_untaken: assert property (p_br_untaken) else $error("untaken branch wrong");
  a_cmp: assert property (p_cmp) else $error("compare wrote a register");
  a_skip: assert property (p_skip) else $error("two word skip wrong");
endmodule : abx_exec_properties

bind abx_exec abx_exec_properties i_abx_exec_properties (.clk(clk), .rst_b(rst_b),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .done(done), .res(res),
  .flags(flags));

// File: verification/abx_fetch_model.sv
// decoder and register file stand-in that feeds the execution unit
// assumes the bench calls send from one process only
`timescale 1ns/1ps
module abx_fetch_model
  import abx_pkg::*;
(
  // clock
  input wire logic     clk,
  // request side
  output logic         req_valid,
  output abx_req_t     req,
  input wire logic     req_ready,
  // completion side
  input wire logic     done,
  input wire abx_res_t res
);
  // ****************************************
  // request driver
  // ****************************************
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // hold one request until taken, then count cycles up to done
  task automatic send(input abx_req_t r, output abx_res_t o, output int cyc);
    int w;
    w = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && w < 16) begin
      @(negedge clk);
      w++;
    end
    req_valid = 1'b1;
    req = r;
    @(negedge clk);
    req_valid = 1'b0;
    req = ~r;  // stale operands must not look valid
    cyc = 1;
    while (done !== 1'b1 && cyc < 8) begin
      @(negedge clk);
      cyc++;
    end
    o = res;
  endtask : send
endmodule : abx_fetch_model

// File: verification/tb_top.sv
// self-checking bench for the alu and branch execution unit
// assumes the fetch stand-in model and the bound checker
`timescale 1ns/1ps
module tb_top
  import abx_pkg::*;
;
  // ****************************************
  // clock, reset and wiring
  // ****************************************
  logic       clk;              // core clock
  logic       rst_b;            // async reset, active low
  logic       req_valid;        // request strobe
  logic       req_ready;        // unit can take a request
  abx_req_t   req;              // request carrier
  logic       done;             // completion pulse
  abx_res_t   res;              // result carrier
  logic [7:0] flags;            // flag register
  abx_req_t   r;                // request template
  abx_res_t   o;                // last result
  int         cyc;              // measured cycle count
  int         miscompares;      // mismatches
  int         samples_checked;  // comparisons made
  int         cycles = 0;       // hang guard

  abx_exec i_abx_exec (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .done(done), .res(res), .flags(flags));
  abx_fetch_model i_abx_fetch_model (.clk(clk), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .res(res));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one instruction: cycles, next pc, write-back and flags
  task op(input abx_cmd_t c, input logic [7:0] a, input logic [7:0] b, input logic [15:0] d,
          input logic wb, input logic [7:0] f, input int n, input logic [15:0] pc);
    r.cmd = c;
    r.rd_val = a;
    r.rr_val = b;
    r.imm = b;
    i_abx_fetch_model.send(r, o, cyc);
    chk(16'(cyc), 16'(n));
    chk(o.pc_next, pc);
    if (wb !== 1'bx) chk({15'h0000, o.wb_en}, {15'h0000, wb});
    if (wb === 1'b1) chk(o.wb_data, d);
    chk({8'h00, flags}, {8'h00, f});
  endtask : op

  task finish_test;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // ****************************************
  // scenarios
  // ****************************************
  task s_arith;
    op(abx_add, 8'h0f, 8'h01, 16'h0010, 1'b1, 8'h20, 1, 16'h0101);
    op(abx_add, 8'h80, 8'h80, 16'h0000, 1'b1, 8'h0b, 1, 16'h0101);
    op(abx_add_carry, 8'h01, 8'h01, 16'h0003, 1'b1, 8'h00, 1, 16'h0101);
    op(abx_minus_regs, 8'h00, 8'h01, 16'h00ff, 1'b1, 8'h25, 1, 16'h0101);
    op(abx_minus_imm_borrow, 8'h10, 8'h00, 16'h000f, 1'b1, 8'h20, 1, 16'h0101);
    op(abx_minus_immediate, 8'h05, 8'h05, 16'h0000, 1'b1, 8'h02, 1, 16'h0101);
    op(abx_minus_regs_borrow, 8'h05, 8'h05, 16'h0000, 1'b1, 8'h02, 1, 16'h0101);
  endtask : s_arith

  task s_word;
    r.pair_val = 16'hffff;
    op(abx_word_pair_plus_imm, 8'hff, 8'h01, 16'h0000, 1'b1, 8'h03, 2, 16'h0101);
    chk({15'h0000, o.wb_pair}, 16'h0001);
    chk({11'h000, o.wb_idx}, 16'h0010);
    r.pair_val = 16'h0000;
    op(abx_word_pair_minus_imm, 8'h00, 8'h01, 16'hffff, 1'b1, 8'h15, 2, 16'h0101);
  endtask : s_word

  task s_logic;
    op(abx_conjunction, 8'hf0, 8'h8f, 16'h0080, 1'b1, 8'h15, 1, 16'h0101);
    op(abx_disjunction_imm, 8'h00, 8'h00, 16'h0000, 1'b1, 8'h13, 1, 16'h0101);
    op(abx_exclusive_disjunction, 8'h55, 8'hff, 16'h00aa, 1'b1, 8'h15, 1, 16'h0101);
    op(abx_set_mask_bits, 8'h01, 8'h80, 16'h0081, 1'b1, 8'h15, 1, 16'h0101);
    op(abx_clear_mask_bits, 8'hff, 8'h80, 16'h007f, 1'b1, 8'h11, 1, 16'h0101);
    op(abx_zero_sign_probe, 8'h80, 8'h00, 16'h0080, 1'b1, 8'h15, 1, 16'h0101);
    op(abx_conjunction_imm, 8'h3c, 8'h0f, 16'h000c, 1'b1, 8'h11, 1, 16'h0101);
    op(abx_disjunction, 8'h00, 8'h00, 16'h0000, 1'b1, 8'h13, 1, 16'h0101);
  endtask : s_logic

  task s_cmp;
    op(abx_compare_regs, 8'h10, 8'h20, 16'h0000, 1'b0, 8'h15, 1, 16'h0101);
    op(abx_compare_immediate, 8'h40, 8'h40, 16'h0000, 1'b0, 8'h12, 1, 16'h0101);
    op(abx_compare_regs_with_borrow, 8'h40, 8'h40, 16'h0000, 1'b0, 8'h12, 1, 16'h0101);
  endtask : s_cmp

  task s_branch;
    r.offset = 12'h010;
    r.flag_sel = 3'h1;
    op(abx_branch_on_zero_flag, 8'h00, 8'h00, 16'h0000, 1'b0, 8'h12, 2, 16'h0111);
    op(abx_branch_flag_low, 8'h00, 8'h00, 16'h0000, 1'b0, 8'h12, 1, 16'h0101);
    op(abx_branch_flag_high, 8'h00, 8'h00, 16'h0000, 1'b0, 8'h12, 2, 16'h0111);
    r.flag_sel = 3'h0;
    op(abx_branch_flag_high, 8'h00, 8'h00, 16'h0000, 1'b0, 8'h12, 1, 16'h0101);
    r.offset = 12'hfff;
    op(abx_branch_flag_low, 8'h00, 8'h00, 16'h0000, 1'b0, 8'h12, 2, 16'h0100);
    op(abx_nop, 8'h00, 8'h00, 16'h0000, 1'b0, 8'h12, 1, 16'h0101);
  endtask : s_branch

  task s_jump;
    r.offset = 12'h800;
    op(abx_pc_relative_jump, 8'h00, 8'h00, 16'h0000, 1'b0, 8'h12, 2, 16'hf901);
    r.z_ptr = 16'h1234;
    op(abx_jump_via_pointer, 8'h00, 8'h00, 16'h0000, 1'b0, 8'h12, 2, 16'h1234);
    r.offset = 12'h005;
    op(abx_pc_relative_call, 8'h00, 8'h00, 16'h0000, 1'b0, 8'h12, 3, 16'h0106);
    chk(o.push_addr, 16'h0101);
    r.z_ptr = 16'h0abc;
    op(abx_call_via_pointer, 8'h00, 8'h00, 16'h0000, 1'b0, 8'h12, 3, 16'h0abc);
    chk({15'h0000, o.push_en}, 16'h0001);
  endtask : s_jump

  task s_skip;
    op(abx_skip_on_equal, 8'h33, 8'h33, 16'h0000, 1'b0, 8'h12, 2, 16'h0102);
    r.next_two_word = 1'b1;
    op(abx_skip_on_equal, 8'h33, 8'h33, 16'h0000, 1'b0, 8'h12, 3, 16'h0103);
    op(abx_skip_on_equal, 8'h33, 8'h34, 16'h0000, 1'b0, 8'h12, 1, 16'h0101);
    r.bit_sel = 3'h3;
    op(abx_skip_reg_bit_low, 8'hf7, 8'hf7, 16'h0000, 1'b0, 8'h12, 3, 16'h0103);
    op(abx_skip_reg_bit_high, 8'hf7, 8'hf7, 16'h0000, 1'b0, 8'h12, 1, 16'h0101);
    r.next_two_word = 1'b0;
    r.bit_sel = 3'h7;
    r.io_val = 8'h80;
    op(abx_skip_io_bit_high, 8'h00, 8'h00, 16'h0000, 1'b0, 8'h12, 2, 16'h0102);
    op(abx_skip_io_bit_low, 8'h00, 8'h00, 16'h0000, 1'b0, 8'h12, 1, 16'h0101);
  endtask : s_skip

  // ****************************************
  // hang guard and main sequence
  // ****************************************
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    rst_b = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    r = '0;
    r.pc = 16'h0100;
    r.dst = 5'h10;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    chk({8'h00, flags}, 16'h0000);
    s_arith();
    s_word();
    s_logic();
    s_cmp();
    s_branch();
    s_jump();
    s_skip();
    finish_test();
  end
endmodule : tb_top
